// ==== logic/cfe_encoder.sv ====
`timescale 1ns/1ps
`include "cfe_params.svh"

// Summary of operation
// - eight selectable coding modes
// - tenth-order predictor, ten coefficients per set
// - 160-sample frames, one parameter set each, two at top rate
// - four 40-sample subframes, codebook parameters each
// - two analyses at top rate, else one
// - top rate: split matrix quantisation, 38 bits
// - other rates: split vector quantisation
// - direct or interpolated coefficients per subframe
// - open-loop lag every second subframe, lowest two once
// - fixed order of eight subframe steps, open-loop step ahead when due
// - pitch resolution sixth or third by mode
// - updated target feeds fixed codebook search
// - scalar 4+5 bit or joint vector gains
// - weighting factors 0.9/0.94 and 0.6
// - exact bit count per frame per mode
// - every field sent msb first
// - top rate field layout
// - 10.2 and 7.40 field layout
// - 7.95 field layout
module cfe_encoder
    import cfe_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [2:0] mode_sel,
    input wire logic sample_valid,
    input wire logic [15:0] sample_data,
    output logic eng_smp_valid,
    output logic [15:0] eng_smp_data,
    output logic [7:0] eng_smp_index,
    output logic step_valid,
    output cfe_step_t step_code,
    output logic [2:0] step_mode,
    output logic [1:0] step_subframe,
    output logic step_lp_set,
    output logic step_interp,
    output logic step_frac_sixth,
    output logic [15:0] step_gamma1,
    output logic [15:0] step_gamma2,
    output logic [3:0] step_lp_order,
    input wire logic step_done,
    input wire logic [37:0] step_result,
    output logic bs_valid,
    output logic bs_bit,
    output logic bs_frame_start,
    input wire logic bs_ready,
    output logic frame_overrun,
    output logic busy,
    output logic [7:0] last_frame_bits
);
    localparam logic [7:0] LAST_SAMPLE = 8'(`CFE_FRAME_SAMPLES - 1);

    cfe_state_t state_reg;
    logic [7:0] samp_cnt_reg;
    logic frame_pending_reg;
    logic overrun_reg;
    logic busy_reg;
    logic [2:0] mode_reg;
    logic lp_pass_reg;
    logic [1:0] sf_reg;
    logic [37:0] lsp_reg;
    logic [8:0] delay_reg;
    logic [34:0] code_reg;
    logic [8:0] gain_reg;
    logic eng_smp_valid_reg;
    logic [15:0] eng_smp_data_reg;
    logic [7:0] eng_smp_index_reg;
    logic step_valid_reg;
    cfe_step_t step_code_reg;
    logic [2:0] step_mode_reg;
    logic [1:0] step_sf_reg;
    logic step_lp_set_reg;
    logic step_interp_reg;
    logic step_sixth_reg;
    logic [15:0] step_g1_reg;
    logic [15:0] step_g2_reg;
    logic [3:0] step_order_reg;
    logic emit_lsp_reg;
    logic [2:0] fld_idx_reg;
    logic [37:0] sh_data_reg;
    logic [5:0] sh_left_reg;
    logic first_pend_reg;
    logic [7:0] bit_cnt_reg;
    logic [7:0] last_bits_reg;
    logic frame_take;
    logic frame_done;
    logic step_fire;
    logic is_step;
    logic emit_done;
    logic bit_take;
    logic [2:0] n_fields;
    logic [37:0] fld_val;
    logic [5:0] fld_w;
    logic [1:0] sf_next;

    cfe_bit_if bit_if ();

    // ----------------------------------------------------------------
    // field width tables
    // ----------------------------------------------------------------
    function automatic logic [5:0] lsp_w(input logic [2:0] m);
        unique case (m)
            `CFE_MODE_122: lsp_w = `CFE_LSP_W_122;
            `CFE_MODE_795: lsp_w = `CFE_LSP_W_795;
            `CFE_MODE_515, `CFE_MODE_475: lsp_w = `CFE_LSP_W_LOW;
            default: lsp_w = `CFE_LSP_W_MID;
        endcase
    endfunction

    function automatic logic [5:0] delay_w(input logic [2:0] m, input logic [1:0] sf);
        unique case (m)
            `CFE_MODE_122: delay_w = sf[0] ? `CFE_DLY_W_6 : `CFE_DLY_W_9;
            `CFE_MODE_102, `CFE_MODE_740: delay_w = sf[0] ? `CFE_DLY_W_5 : `CFE_DLY_W_8;
            `CFE_MODE_795: delay_w = sf[0] ? `CFE_DLY_W_6 : `CFE_DLY_W_8;
            `CFE_MODE_670, `CFE_MODE_590: delay_w = sf[0] ? `CFE_DLY_W_4 : `CFE_DLY_W_8;
            default: delay_w = (sf == 2'h0) ? `CFE_DLY_W_8 : `CFE_DLY_W_4;
        endcase
    endfunction

    function automatic logic scalar_gain(input logic [2:0] m);
        scalar_gain = (m == `CFE_MODE_122) || (m == `CFE_MODE_795);
    endfunction

    function automatic logic [5:0] code_w(input logic [2:0] m);
        unique case (m)
            `CFE_MODE_122: code_w = `CFE_CODE_W_122;
            `CFE_MODE_102: code_w = `CFE_CODE_W_102;
            `CFE_MODE_795, `CFE_MODE_740: code_w = `CFE_CODE_W_17;
            `CFE_MODE_670: code_w = `CFE_CODE_W_670;
            `CFE_MODE_590: code_w = `CFE_CODE_W_590;
            default: code_w = `CFE_CODE_W_LOW;
        endcase
    endfunction

    // lowest rate shares one joint gain index across each subframe pair
    function automatic logic [5:0] cgain_w(input logic [2:0] m, input logic [1:0] sf);
        unique case (m)
            `CFE_MODE_122, `CFE_MODE_795: cgain_w = `CFE_CGAIN_W;
            `CFE_MODE_102, `CFE_MODE_740, `CFE_MODE_670: cgain_w = `CFE_JGAIN_W_7;
            `CFE_MODE_590, `CFE_MODE_515: cgain_w = `CFE_JGAIN_W_6;
            default: cgain_w = sf[0] ? `CFE_ZERO_W : `CFE_JGAIN_W_475;
        endcase
    endfunction

    function automatic logic olp_needed(input logic [2:0] m, input logic [1:0] sf);
        if ((m == `CFE_MODE_515) || (m == `CFE_MODE_475)) begin
            olp_needed = (sf == 2'h0);
        end else begin
            olp_needed = ~sf[0];
        end
    endfunction

    // ----------------------------------------------------------------
    // sample intake and frame timing
    // ----------------------------------------------------------------
    assign frame_done = sample_valid && (samp_cnt_reg == LAST_SAMPLE);
    assign frame_take = (state_reg == ST_IDLE) && frame_pending_reg;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            samp_cnt_reg <= 8'h00;
            eng_smp_valid_reg <= 1'b0;
            eng_smp_data_reg <= 16'h0000;
            eng_smp_index_reg <= 8'h00;
        end else begin
            eng_smp_valid_reg <= sample_valid;
            if (sample_valid) begin
                // low bits cleared so a sloppy source cannot leak noise below 13 bits
                eng_smp_data_reg <= sample_data & `CFE_SAMPLE_MASK;
                eng_smp_index_reg <= samp_cnt_reg;
                samp_cnt_reg <= frame_done ? 8'h00 : samp_cnt_reg + 8'h01;
            end
        end
    end

    // a frame finishing in the cycle its predecessor is taken stays pending
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            frame_pending_reg <= 1'b0;
            overrun_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            if (frame_done) begin
                frame_pending_reg <= 1'b1;
            end else if (frame_take) begin
                frame_pending_reg <= 1'b0;
            end
            overrun_reg <= frame_done && frame_pending_reg && !frame_take;
            busy_reg <= (state_reg != ST_IDLE);
        end
    end

    // ----------------------------------------------------------------
    // frame and subframe sequencer
    // ----------------------------------------------------------------
    assign step_fire = step_valid_reg && step_done;
    assign is_step = (state_reg != ST_IDLE) && (state_reg != ST_EMIT);
    assign sf_next = sf_reg + 2'h1;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            mode_reg <= `CFE_MODE_122;
            lp_pass_reg <= 1'b0;
            sf_reg <= 2'h0;
            emit_lsp_reg <= 1'b0;
            lsp_reg <= 38'h0;
            delay_reg <= 9'h000;
            code_reg <= 35'h0;
            gain_reg <= 9'h000;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    if (frame_take) begin
                        // mode is sampled once; the source keeps it stable meanwhile
                        mode_reg <= mode_sel;
                        lp_pass_reg <= 1'b0;
                        sf_reg <= 2'h0;
                        state_reg <= ST_LP;
                    end
                end
                ST_LP: begin
                    if (step_fire) begin
                        if ((mode_reg == `CFE_MODE_122) && !lp_pass_reg) begin
                            lp_pass_reg <= 1'b1;
                        end else begin
                            state_reg <= ST_LSPQ;
                        end
                    end
                end
                ST_LSPQ: begin
                    if (step_fire) begin
                        lsp_reg <= step_result;
                        emit_lsp_reg <= 1'b1;
                        state_reg <= ST_EMIT;
                    end
                end
                ST_OLP: if (step_fire) state_reg <= ST_COEF;
                ST_COEF: if (step_fire) state_reg <= ST_TARGET;
                ST_TARGET: if (step_fire) state_reg <= ST_IMPULSE;
                ST_IMPULSE: if (step_fire) state_reg <= ST_PITCH;
                ST_PITCH: begin
                    if (step_fire) begin
                        delay_reg <= step_result[8:0];
                        state_reg <= ST_UPD;
                    end
                end
                ST_UPD: if (step_fire) state_reg <= ST_CODE;
                ST_CODE: begin
                    if (step_fire) begin
                        code_reg <= step_result[34:0];
                        state_reg <= ST_GAIN;
                    end
                end
                ST_GAIN: begin
                    if (step_fire) begin
                        gain_reg <= step_result[8:0];
                        state_reg <= ST_MEM;
                    end
                end
                ST_MEM: begin
                    if (step_fire) begin
                        emit_lsp_reg <= 1'b0;
                        state_reg <= ST_EMIT;
                    end
                end
                ST_EMIT: begin
                    if (emit_done) begin
                        if (emit_lsp_reg) begin
                            state_reg <= olp_needed(mode_reg, 2'h0) ? ST_OLP : ST_COEF;
                        end else if (sf_reg == 2'(`CFE_SUBFRAMES - 1)) begin
                            state_reg <= ST_IDLE;
                        end else begin
                            sf_reg <= sf_next;
                            state_reg <= olp_needed(mode_reg, sf_next) ? ST_OLP : ST_COEF;
                        end
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // step requests to the arithmetic engine
    // ----------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            step_valid_reg <= 1'b0;
            step_code_reg <= STEP_NONE;
            step_mode_reg <= 3'h0;
            step_sf_reg <= 2'h0;
            step_lp_set_reg <= 1'b0;
            step_interp_reg <= 1'b0;
            step_sixth_reg <= 1'b0;
            step_g1_reg <= 16'h0000;
            step_g2_reg <= 16'h0000;
            step_order_reg <= `CFE_LP_ORDER;
        end else if (step_valid_reg) begin
            if (step_done) begin
                step_valid_reg <= 1'b0;
            end
        end else if (is_step) begin
            step_valid_reg <= 1'b1;
            step_mode_reg <= mode_reg;
            step_sf_reg <= sf_reg;
            step_lp_set_reg <= lp_pass_reg;
            step_order_reg <= `CFE_LP_ORDER;
            step_sixth_reg <= (mode_reg == `CFE_MODE_122);
            step_g1_reg <= ((mode_reg == `CFE_MODE_122) || (mode_reg == `CFE_MODE_102)) ?
                           `CFE_GAMMA1_HI : `CFE_GAMMA1_LO;
            step_g2_reg <= `CFE_GAMMA2;
            if (mode_reg == `CFE_MODE_122) begin
                step_interp_reg <= ~sf_reg[0];
            end else begin
                step_interp_reg <= (sf_reg != 2'h3);
            end
            unique case (state_reg)
                ST_LP: step_code_reg <= STEP_LP_ANALYSIS;
                ST_LSPQ: step_code_reg <= (mode_reg == `CFE_MODE_122) ?
                                          STEP_SPLIT_MATRIX_QUANT : STEP_SPLIT_VECTOR_QUANT;
                ST_OLP: step_code_reg <= STEP_OPEN_LOOP;
                ST_COEF: step_code_reg <= STEP_COEF_SEL;
                ST_TARGET: step_code_reg <= STEP_TARGET;
                ST_IMPULSE: step_code_reg <= STEP_IMPULSE;
                ST_PITCH: step_code_reg <= STEP_PITCH;
                ST_UPD: step_code_reg <= STEP_UPDATED_TARGET;
                ST_CODE: step_code_reg <= STEP_CODEBOOK;
                ST_GAIN: step_code_reg <= scalar_gain(mode_reg) ?
                                          STEP_GAIN_SCALAR : STEP_GAIN_VECTOR;
                ST_MEM: step_code_reg <= STEP_MEM_UPDATE;
                default: step_code_reg <= STEP_NONE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // field selection and msb-first serialiser
    // ----------------------------------------------------------------
    always_comb begin
        fld_val = 38'h0;
        fld_w = `CFE_ZERO_W;
        n_fields = emit_lsp_reg ? 3'h1 : 3'h4;
        if (emit_lsp_reg) begin
            fld_val = lsp_reg;
            fld_w = lsp_w(mode_reg);
        end else begin
            unique case (fld_idx_reg)
                3'h0: begin
                    fld_val = {29'h0, delay_reg};
                    fld_w = delay_w(mode_reg, sf_reg);
                end
                3'h1: begin
                    fld_val = {34'h0, gain_reg[8:5]};
                    fld_w = scalar_gain(mode_reg) ? `CFE_PGAIN_W : `CFE_ZERO_W;
                end
                3'h2: begin
                    fld_val = {3'h0, code_reg};
                    fld_w = code_w(mode_reg);
                end
                default: begin
                    fld_val = scalar_gain(mode_reg) ? {33'h0, gain_reg[4:0]} : {30'h0, gain_reg[7:0]};
                    fld_w = cgain_w(mode_reg, sf_reg);
                end
            endcase
        end
    end

    assign emit_done = (state_reg == ST_EMIT) && (sh_left_reg == 6'h00) && (fld_idx_reg == n_fields);
    assign bit_if.valid = (state_reg == ST_EMIT) && (sh_left_reg != 6'h00);
    assign bit_if.bit_val = sh_data_reg[sh_left_reg - 6'h01];
    assign bit_if.first = first_pend_reg;
    assign bit_take = bit_if.valid && bit_if.ready;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            fld_idx_reg <= 3'h0;
            sh_data_reg <= 38'h0;
            sh_left_reg <= 6'h00;
        end else if (state_reg != ST_EMIT) begin
            fld_idx_reg <= 3'h0;
        end else if (sh_left_reg == 6'h00) begin
            if (fld_idx_reg != n_fields) begin
                sh_data_reg <= fld_val;
                sh_left_reg <= fld_w;
                fld_idx_reg <= fld_idx_reg + 3'h1;
            end
        end else if (bit_take) begin
            sh_left_reg <= sh_left_reg - 6'h01;
        end
    end

    // strobe is armed at frame start so it lands on the first spectral bit
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            first_pend_reg <= 1'b0;
            bit_cnt_reg <= 8'h00;
            last_bits_reg <= 8'h00;
        end else begin
            if (frame_take) begin
                first_pend_reg <= 1'b1;
            end else if (bit_take) begin
                first_pend_reg <= 1'b0;
            end
            if (bit_take) begin
                bit_cnt_reg <= first_pend_reg ? 8'h01 : bit_cnt_reg + 8'h01;
            end
            if (emit_done && !emit_lsp_reg && (sf_reg == 2'h3)) begin
                last_bits_reg <= bit_cnt_reg;
            end
        end
    end

    cfe_bit_buf u_buf (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .in_if(bit_if),
        .out_valid(bs_valid),
        .out_bit(bs_bit),
        .out_first(bs_frame_start),
        .out_ready(bs_ready)
    );

    assign eng_smp_valid = eng_smp_valid_reg;
    assign eng_smp_data = eng_smp_data_reg;
    assign eng_smp_index = eng_smp_index_reg;
    assign step_valid = step_valid_reg;
    assign step_code = step_code_reg;
    assign step_mode = step_mode_reg;
    assign step_subframe = step_sf_reg;
    assign step_lp_set = step_lp_set_reg;
    assign step_interp = step_interp_reg;
    assign step_frac_sixth = step_sixth_reg;
    assign step_gamma1 = step_g1_reg;
    assign step_gamma2 = step_g2_reg;
    assign step_lp_order = step_order_reg;
    assign frame_overrun = overrun_reg;
    assign busy = busy_reg;
    assign last_frame_bits = last_bits_reg;
endmodule

// ==== logic/cfe_params.svh ====
`ifndef CFE_PARAMS_SVH
`define CFE_PARAMS_SVH

// ----------------------------------------------------------------
// mode selection codes, lowest rate first
// ----------------------------------------------------------------
`define CFE_MODE_475 3'h0
`define CFE_MODE_515 3'h1
`define CFE_MODE_590 3'h2
`define CFE_MODE_670 3'h3
`define CFE_MODE_740 3'h4
`define CFE_MODE_795 3'h5
`define CFE_MODE_102 3'h6
`define CFE_MODE_122 3'h7

// ----------------------------------------------------------------
// framing
// ----------------------------------------------------------------
`define CFE_SAMPLE_RATE 8000
`define CFE_FRAME_MS 20
`define CFE_FRAME_SAMPLES ((`CFE_SAMPLE_RATE * `CFE_FRAME_MS) / 1000)
`define CFE_SUBFRAMES 4
`define CFE_LP_ORDER 4'hA
`define CFE_SAMPLE_MASK 16'hFFF8

// ----------------------------------------------------------------
// weighting factors, unsigned q15
// ----------------------------------------------------------------
`define CFE_GAMMA1_HI 16'h7333
`define CFE_GAMMA1_LO 16'h7852
`define CFE_GAMMA2 16'h4CCD

// ----------------------------------------------------------------
// field widths in bits
// ----------------------------------------------------------------
`define CFE_LSP_W_122 6'h26
`define CFE_LSP_W_795 6'h1B
`define CFE_LSP_W_MID 6'h1A
`define CFE_LSP_W_LOW 6'h17
`define CFE_DLY_W_9 6'h09
`define CFE_DLY_W_8 6'h08
`define CFE_DLY_W_6 6'h06
`define CFE_DLY_W_5 6'h05
`define CFE_DLY_W_4 6'h04
`define CFE_PGAIN_W 6'h04
`define CFE_CGAIN_W 6'h05
`define CFE_CODE_W_122 6'h23
`define CFE_CODE_W_102 6'h1F
`define CFE_CODE_W_17 6'h11
`define CFE_CODE_W_670 6'h0E
`define CFE_CODE_W_590 6'h0B
`define CFE_CODE_W_LOW 6'h09
`define CFE_JGAIN_W_7 6'h07
`define CFE_JGAIN_W_6 6'h06
`define CFE_JGAIN_W_475 6'h08
`define CFE_ZERO_W 6'h00

`endif

// ==== logic/cfe_pkg.sv ====
package cfe_pkg;

    typedef enum {
        ST_IDLE, ST_LP, ST_LSPQ, ST_OLP, ST_COEF, ST_TARGET, ST_IMPULSE,
        ST_PITCH, ST_UPD, ST_CODE, ST_GAIN, ST_MEM, ST_EMIT
    } cfe_state_t;

    typedef enum logic [3:0] {
        STEP_NONE, STEP_LP_ANALYSIS, STEP_SPLIT_MATRIX_QUANT, STEP_SPLIT_VECTOR_QUANT,
        STEP_OPEN_LOOP, STEP_COEF_SEL, STEP_TARGET, STEP_IMPULSE, STEP_PITCH,
        STEP_UPDATED_TARGET, STEP_CODEBOOK, STEP_GAIN_SCALAR, STEP_GAIN_VECTOR,
        STEP_MEM_UPDATE
    } cfe_step_t;

endpackage

// ==== logic/cfe_bit_if.sv ====
`timescale 1ns/1ps

interface cfe_bit_if;
    logic valid;
    logic ready;
    logic bit_val;
    logic first;

    modport src (output valid, output bit_val, output first, input ready);
    modport snk (input valid, input bit_val, input first, output ready);
endinterface

// ==== logic/cfe_bit_buf.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------
// two-entry skid buffer for the output bitstream
// ----------------------------------------------------------------
module cfe_bit_buf (
    input wire logic sys_clk,
    input wire logic rst_n,
    cfe_bit_if.snk in_if,
    output logic out_valid,
    output logic out_bit,
    output logic out_first,
    input wire logic out_ready
);
    logic skid_valid_reg;
    logic [1:0] skid_reg;
    logic out_valid_reg;
    logic [1:0] out_reg;
    logic push;

    // ready depends on a flop only, so the emitter never sees a combinational loop
    assign in_if.ready = ~skid_valid_reg;
    assign push = in_if.valid & ~skid_valid_reg;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            out_valid_reg <= 1'b0;
            out_reg <= 2'h0;
            skid_valid_reg <= 1'b0;
            skid_reg <= 2'h0;
        end else if (!out_valid_reg || out_ready) begin
            if (skid_valid_reg) begin
                out_reg <= skid_reg;
                out_valid_reg <= 1'b1;
                skid_valid_reg <= 1'b0;
            end else if (push) begin
                out_reg <= {in_if.first, in_if.bit_val};
                out_valid_reg <= 1'b1;
            end else begin
                out_valid_reg <= 1'b0;
            end
        end else if (push) begin
            skid_reg <= {in_if.first, in_if.bit_val};
            skid_valid_reg <= 1'b1;
        end
    end

    assign out_valid = out_valid_reg;
    assign out_bit = out_reg[0];
    assign out_first = out_reg[1];
endmodule

// ==== tb/cfe_encoder_asserts.sv ====
`timescale 1ns/1ps
module cfe_encoder_asserts
    import cfe_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sample_valid,
    input wire logic [15:0] sample_data,
    input wire logic eng_smp_valid,
    input wire logic [15:0] eng_smp_data,
    input wire logic step_valid,
    input wire cfe_step_t step_code,
    input wire logic [2:0] step_mode,
    input wire logic [1:0] step_subframe,
    input wire logic step_lp_set,
    input wire logic step_interp,
    input wire logic step_frac_sixth,
    input wire logic [15:0] step_gamma1,
    input wire logic [15:0] step_gamma2,
    input wire logic [3:0] step_lp_order,
    input wire logic step_done,
    input wire logic bs_valid,
    input wire logic bs_bit,
    input wire logic bs_frame_start,
    input wire logic bs_ready
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    AST_SMP_MASK: assert property (sample_valid |=> eng_smp_valid
        && eng_smp_data == ($past(sample_data) & 16'hFFF8)) else $error("sample echo wrong");
    AST_WEIGHT: assert property (step_valid |-> step_gamma2 == 16'h4CCD && step_lp_order == 4'hA
        && step_gamma1 == (step_mode >= 3'h6 ? 16'h7333 : 16'h7852)) else $error("weighting wrong");
    AST_FRAC: assert property (step_valid |-> step_frac_sixth == (step_mode == 3'h7))
        else $error("pitch resolution wrong");
    AST_INTERP: assert property (step_valid |-> step_interp == (step_mode == 3'h7 ? !step_subframe[0]
        : step_subframe != 2'h3)) else $error("coefficient choice wrong");
    AST_LP_TWICE: assert property (step_valid && step_code == STEP_LP_ANALYSIS && step_lp_set
        |-> step_mode == 3'h7) else $error("second analysis off top rate");
    AST_QUANT: assert property (step_valid && step_code inside {STEP_SPLIT_MATRIX_QUANT, STEP_SPLIT_VECTOR_QUANT}
        |-> (step_code == STEP_SPLIT_MATRIX_QUANT) == (step_mode == 3'h7)) else $error("quantiser kind wrong");
    AST_OPEN_LOOP: assert property (step_valid && step_code == STEP_OPEN_LOOP
        |-> !step_subframe[0] && (step_mode > 3'h1 || step_subframe == 2'h0)) else $error("open-loop misplaced");
    AST_GAIN_KIND: assert property (step_valid && step_code inside {STEP_GAIN_SCALAR, STEP_GAIN_VECTOR}
        |-> (step_code == STEP_GAIN_SCALAR) == (step_mode inside {3'h5, 3'h7})) else $error("gain kind wrong");
    AST_STEP_HOLD: assert property (step_valid && !step_done |=> step_valid && $stable(step_code))
        else $error("step dropped early");
    AST_BIT_HOLD: assert property (bs_valid && !bs_ready |=> bs_valid && $stable(bs_bit))
        else $error("stalled bit changed");
    COV_TOP: cover property (step_valid && step_code == STEP_SPLIT_MATRIX_QUANT);
    COV_STALL: cover property (bs_valid && !bs_ready);
    COV_FRAME: cover property (bs_valid && bs_ready && bs_frame_start);
endmodule
bind cfe_encoder cfe_encoder_asserts u_chk (.*);

// ==== tb/cfe_step_model.sv ====
`timescale 1ns/1ps
// result of one makes every field but the scalar pitch gain (all zero) end in a single one, so bit order shows
module cfe_step_model (
    input wire logic sys_clk,
    input wire logic step_valid,
    output logic step_done = 1'b0,
    output logic [37:0] step_result = 38'h1
);
    logic [2:0] wait_reg = 3'h0;
    always @(posedge sys_clk) begin
        step_done <= step_valid && !step_done && wait_reg == 3'h0;
        if (!step_valid) wait_reg <= 3'($urandom % 4);
        else if (wait_reg != 3'h0) wait_reg <= wait_reg - 3'h1;
    end
endmodule

// ==== tb/cfe_encoder_tb.sv ====
`timescale 1ns/1ps
module cfe_encoder_tb;
    import cfe_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic sample_valid = 1'b0;
    logic bs_ready = 1'b0;
    logic [2:0] mode_sel = 3'h0;
    logic [15:0] sample_data = 16'h0000;
    logic eng_smp_valid, step_valid, step_lp_set, step_interp, step_frac_sixth, step_done, bs_valid, bs_bit;
    logic bs_frame_start, frame_overrun, busy;
    logic [15:0] eng_smp_data, step_gamma1, step_gamma2;
    logic [7:0] eng_smp_index, last_frame_bits;
    logic [2:0] step_mode;
    logic [1:0] step_subframe;
    logic [3:0] step_lp_order;
    logic [37:0] step_result;
    cfe_step_t step_code;
    int num_errors = 0;
    int checks_done = 0;
    int exp_q[$];
    int cur_exp = 0;
    int nbits = 0;
    int tot[8] = '{95, 103, 118, 134, 148, 159, 204, 244};
    int lsp[8] = '{23, 23, 26, 26, 26, 27, 26, 38};
    cfe_encoder u_dut (.*);
    cfe_step_model u_eng (.sys_clk(sys_clk), .step_valid(step_valid), .step_done(step_done), .step_result(step_result));
    always #2.5 sys_clk = ~sys_clk;
    always @(negedge sys_clk) bs_ready <= ($urandom % 4) != 0;
    task automatic check(input string name, input int exp, input int seen);
        checks_done++;
        if (exp !== seen) begin
            num_errors++;
            $display("[ERR] %s expected %0d seen %0d", name, exp, seen);
        end
    endtask
    task automatic results();
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // mode stays put until the frame has fully left, the encoder latches it late
    task automatic send_frame(input int m);
        int t;
        mode_sel = 3'(m);
        exp_q.push_back(tot[m] * 64 + lsp[m]);
        for (int i = 0; i < 160; i++) begin
            if ($urandom % 2) begin
                sample_valid = 1'b0;
                @(negedge sys_clk);
            end
            sample_data = 16'($urandom) & 16'hFFF8;
            sample_valid = 1'b1;
            @(negedge sys_clk);
            check("sample index", i, eng_smp_index);
        end
        sample_valid = 1'b0;
        for (t = 0; t < 3000 && (exp_q.size() != 0 || busy !== 1'b0 || bs_valid !== 1'b0); t++) @(negedge sys_clk);
        check("frame drain", 1, int'(t < 3000));
        check("last frame bits", tot[m], last_frame_bits);
    endtask
    always @(posedge sys_clk) begin
        if (bs_valid === 1'b1 && bs_ready === 1'b1) begin
            if (bs_frame_start === 1'b1) begin
                if (cur_exp != 0) check("frame bits", cur_exp / 64, nbits);
                cur_exp = exp_q.size() != 0 ? exp_q.pop_front() : 0;
                check("frame start", 1, int'(cur_exp != 0));
                nbits = 0;
            end
            if (bs_bit === 1'b1 && nbits < cur_exp % 64) check("spectral msb", cur_exp % 64 - 1, nbits);
            nbits++;
        end
        if (rst_n && frame_overrun !== 1'b0) check("frame overrun", 0, 1);
    end
    initial begin
        void'($urandom(32'h6D1B580A));
        repeat (16) @(negedge sys_clk);
        rst_n = 1'b1;
        for (int m = 0; m < 8; m++) send_frame(m);
        for (int k = 0; k < 4; k++) send_frame(int'($urandom % 8));
        check("frame bits", cur_exp / 64, nbits);
        results();
    end
    initial begin
        #(12 * 1500 * 5);
        num_errors++;
        results();
    end
endmodule
